// File: hw/adc_pmr_pkg.sv
// Purpose: constants for the converter power, mode and reset control block
// Assumes: 125 MHz peripheral clock, asynchronous active-low reset
// Notes:   control bits are plain ports, no register bus
package adc_pmr_pkg;

  localparam int unsigned PORT_WIDTH      = 8;
  localparam int unsigned CHANNELS        = 8;
  localparam int unsigned BLOCK_BYTES     = 16;
  localparam logic        PWR_UP_RST      = 1'b0;
  localparam logic        HALT_WAIT_RST   = 1'b0;
  localparam logic [1:0]  FRZ_SEL_RST     = 2'h0;
  localparam logic [7:0]  CTL_ZERO_ONE_RD = 8'h00;

  typedef enum logic [1:0] {
    FRZ_IGNORE = 2'b00,
    FRZ_FINISH = 2'b10,
    FRZ_NOW    = 2'b11
  } frz_sel_t;

  typedef enum logic [1:0] {
    ST_DOWN   = 2'b00,
    ST_IDLE   = 2'b01,
    ST_RUN    = 2'b10,
    ST_FROZEN = 2'b11
  } adc_state_t;

endpackage

// File: hw/adc_power_mode_reset_control.sv
// Purpose: power-down, idle, run and freeze control for an 8-channel ADC
// Assumes: sequencer reports conversion start/end as one-cycle pulses
// Notes:   freeze select 2'b01 is treated like ignore
module adc_power_mode_reset_control #(
  parameter int unsigned PORT_W = adc_pmr_pkg::PORT_WIDTH,
  parameter int unsigned CH_N   = adc_pmr_pkg::CHANNELS
) (
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              arst_n_i,
  // chip mode conditions
  input  wire logic              chip_stop_i,
  input  wire logic              chip_wait_i,
  input  wire logic              background_debug_signal_i,
  input  wire logic              special_mode_i,
  // control bit writes
  input  wire logic              ctl_two_wr_i,
  input  wire logic              power_up_ctl_i,
  input  wire logic              halt_in_wait_ctl_i,
  input  wire logic              ctl_three_wr_i,
  input  wire logic [1:0]        freeze_sel_i,
  input  wire logic              ctl_four_wr_i,
  input  wire logic              ctl_five_wr_i,
  input  wire logic              soft_reset_wr_i,
  input  wire logic              bus_access_i,
  input  wire logic              port_rd_i,
  // sequencer status
  input  wire logic              seq_active_i,
  input  wire logic              conv_busy_i,
  input  wire logic              sample_start_i,
  input  wire logic              conv_done_i,
  input  wire logic [CH_N-1:0]   conv_done_set_i,
  input  wire logic              seq_done_set_i,
  // analog pins
  input  wire logic [PORT_W-1:0] analog_pin_i,
  // control outputs
  output logic                   power_up_ctl_o,
  output logic                   halt_in_wait_ctl_o,
  output logic [1:0]             freeze_sel_o,
  output logic                   analog_bias_en_o,
  output logic                   digital_clk_en_o,
  output logic                   submod_clk_en_o,
  output logic                   seq_abort_o,
  output logic                   seq_start_o,
  output logic                   module_reset_o,
  output logic                   reg_access_ok_o,
  output logic                   ctl_zero_one_rd_en_o,
  output logic [CH_N-1:0]        conversion_done_flag_o,
  output logic                   sequence_done_flag_o,
  output logic [PORT_W-1:0]      analog_pin_port_data_o,
  output adc_pmr_pkg::adc_state_t state_o
);

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  logic [PORT_W-1:0] pin_s1_q;
  logic [PORT_W-1:0] pin_s2_q;
  logic [2:0]        mode_s1_q;
  logic [2:0]        mode_s2_q;
  logic              stop_s;
  logic              wait_s;
  logic              dbg_s;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1_q  <= '0;
      pin_s2_q  <= '0;
      mode_s1_q <= 3'h0;
      mode_s2_q <= 3'h0;
    end else begin
      pin_s1_q  <= analog_pin_i;
      pin_s2_q  <= pin_s1_q;
      mode_s1_q <= {background_debug_signal_i, chip_wait_i, chip_stop_i};
      mode_s2_q <= mode_s1_q;
    end
  end

  assign stop_s = mode_s2_q[0];
  assign wait_s = mode_s2_q[1];
  assign dbg_s  = mode_s2_q[2];

  // ------------------------------------------------------------------
  // module reset and control bits
  // ------------------------------------------------------------------
  logic soft_rst;
  logic restart;
  logic pwr_up_q;
  logic halt_wait_q;
  logic [1:0] frz_sel_q;

  assign soft_rst       = soft_reset_wr_i;
  assign restart        = ctl_four_wr_i | ctl_five_wr_i;
  assign module_reset_o = soft_rst;

  // power_up_ctl is reset only by the system reset
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_up_q <= adc_pmr_pkg::PWR_UP_RST;
    end else if (ctl_two_wr_i) begin
      pwr_up_q <= power_up_ctl_i;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      halt_wait_q <= adc_pmr_pkg::HALT_WAIT_RST;
      frz_sel_q   <= adc_pmr_pkg::FRZ_SEL_RST;
    end else if (soft_rst) begin
      halt_wait_q <= adc_pmr_pkg::HALT_WAIT_RST;
      frz_sel_q   <= adc_pmr_pkg::FRZ_SEL_RST;
    end else begin
      if (ctl_two_wr_i) begin
        halt_wait_q <= halt_in_wait_ctl_i;
      end
      if (ctl_three_wr_i) begin
        frz_sel_q <= freeze_sel_i;
      end
    end
  end

  assign power_up_ctl_o     = pwr_up_q;
  assign halt_in_wait_ctl_o = halt_wait_q;
  assign freeze_sel_o       = frz_sel_q;

  // ------------------------------------------------------------------
  // power-down and freeze decode
  // ------------------------------------------------------------------
  logic wait_down;
  logic pwr_down;
  logic frz_now;
  logic frz_finish;
  logic frozen_q;

  assign wait_down = wait_s & halt_wait_q;
  assign pwr_down  = ~pwr_up_q | stop_s | wait_down;
  assign frz_now   = dbg_s & (frz_sel_q == adc_pmr_pkg::FRZ_NOW);
  assign frz_finish = dbg_s & (frz_sel_q == adc_pmr_pkg::FRZ_FINISH);

  // finish-mode freeze waits for the conversion end; freezing on a sample
  // start would cut that sample, so a sequencer about to sample runs on
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frozen_q <= 1'b0;
    end else if (!dbg_s || pwr_down) begin
      frozen_q <= 1'b0;
    end else if (frz_now) begin
      frozen_q <= 1'b1;
    end else if (frz_finish && (conv_done_i ||
                 (!conv_busy_i && !sample_start_i))) begin
      frozen_q <= 1'b1;
    end
  end

  // wait power-down holds everything, so the sequence is not aborted
  // and the module resumes where it stood
  assign seq_abort_o = soft_rst | restart |
                       ((~pwr_up_q | stop_s) & seq_active_i);
  assign seq_start_o = restart & ~soft_rst & ~pwr_down;

  assign analog_bias_en_o = ~pwr_down;
  assign digital_clk_en_o = ~pwr_down & ~frozen_q;
  assign submod_clk_en_o  = digital_clk_en_o & seq_active_i;
  assign reg_access_ok_o  = ~wait_down | ~pwr_up_q;
  assign ctl_zero_one_rd_en_o = special_mode_i;

  // ------------------------------------------------------------------
  // completion flags; set wins over restart clear, reset clears all
  // ------------------------------------------------------------------
  logic [CH_N-1:0] ccf_q;
  logic            scf_q;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ccf_q <= '0;
      scf_q <= 1'b0;
    end else if (soft_rst) begin
      ccf_q <= '0;
      scf_q <= 1'b0;
    end else if (restart) begin
      ccf_q <= conv_done_set_i;
      scf_q <= seq_done_set_i;
    end else begin
      ccf_q <= ccf_q | conv_done_set_i;
      scf_q <= scf_q | seq_done_set_i;
    end
  end

  assign conversion_done_flag_o = ccf_q;
  assign sequence_done_flag_o   = scf_q;

  // ------------------------------------------------------------------
  // digital input port: reads touch no conversion state
  // ------------------------------------------------------------------
  logic [PORT_W-1:0] port_q;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port_q <= '0;
    end else if (port_rd_i) begin
      port_q <= pin_s2_q;
    end
  end

  assign analog_pin_port_data_o = port_q;

  // ------------------------------------------------------------------
  // state indication
  // ------------------------------------------------------------------
  always_comb begin
    if (pwr_down) begin
      state_o = adc_pmr_pkg::ST_DOWN;
    end else if (frozen_q) begin
      state_o = adc_pmr_pkg::ST_FROZEN;
    end else if (seq_active_i) begin
      state_o = adc_pmr_pkg::ST_RUN;
    end else begin
      state_o = adc_pmr_pkg::ST_IDLE;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  chk_pwr_bit_down: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    !pwr_up_q |-> !digital_clk_en_o && !analog_bias_en_o)
    else $error("power bit clear but clocks on");
  chk_stop_down: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    $rose(mode_s2_q[0]) |-> state_o == adc_pmr_pkg::ST_DOWN)
    else $error("stop did not power down");
  chk_wait_ignored: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    wait_s && !halt_wait_q && pwr_up_q && !stop_s |-> analog_bias_en_o)
    else $error("wait acted with halt bit clear");
  chk_abort_on_off: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    ctl_two_wr_i && !power_up_ctl_i && seq_active_i
    |=> seq_abort_o || !seq_active_i)
    else $error("sequence not aborted");
  chk_bit_down_access: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    !pwr_up_q |-> reg_access_ok_o)
    else $error("no access while powered down by bit");
  chk_wait_noaccess: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    wait_down && pwr_up_q |-> !reg_access_ok_o)
    else $error("access during wait power-down");
  chk_idle_gated: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    state_o == adc_pmr_pkg::ST_IDLE |-> !submod_clk_en_o && reg_access_ok_o)
    else $error("submodule clocks run while idle");
  chk_freeze_now: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    frz_now && !pwr_down |=> frozen_q || !dbg_s)
    else $error("immediate freeze missed");
  chk_finish_halt: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    frz_finish && conv_done_i && !pwr_down |=> frozen_q || !dbg_s)
    else $error("finish freeze missed conversion end");
  chk_finish_no_sample: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    frz_finish && !frozen_q && sample_start_i |=> !frozen_q)
    else $error("finish freeze cut a sample");
  chk_frozen_hold: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    frozen_q && !pwr_down |-> analog_bias_en_o && reg_access_ok_o
    && !digital_clk_en_o)
    else $error("frozen state not static");
  chk_soft_keeps_pwr: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    soft_rst && !ctl_two_wr_i |=> $stable(pwr_up_q))
    else $error("soft reset changed power bit");
  chk_reset_flags: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    soft_rst |=> ccf_q == '0 && !scf_q)
    else $error("flags survive module reset");
  chk_wait_keeps_seq: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    wait_down && pwr_up_q && !stop_s && !restart && !soft_rst
    |-> !seq_abort_o)
    else $error("wait power-down aborted the sequence");
  chk_freeze_no_reset: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    $fell(frozen_q) && !soft_rst && !restart && !pwr_down
    |-> !seq_abort_o && !module_reset_o)
    else $error("leaving freeze reset the module");
  chk_restart_start: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    restart && !soft_rst && !pwr_down
    |-> seq_start_o && seq_abort_o)
    else $error("restart did not start");
  chk_port_capture: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    port_rd_i |=> analog_pin_port_data_o == $past(pin_s2_q))
    else $error("port read did not capture pins");
  chk_ctl23_quiet: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    (ctl_two_wr_i || ctl_three_wr_i) && !restart && !soft_rst && pwr_up_q
    && !stop_s |-> !seq_start_o)
    else $error("control two or three started a sequence");
  chk_restart_clear: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    restart && !soft_rst && !seq_done_set_i |=> !sequence_done_flag_o)
    else $error("restart left sequence flag set");

  cov_wait_down: cover property (@(posedge clock_i) wait_down ##1 !wait_down);
  cov_frozen: cover property (@(posedge clock_i) $rose(frozen_q));
  cov_restart: cover property (@(posedge clock_i) seq_start_o);
  cov_soft: cover property (@(posedge clock_i) soft_rst && pwr_up_q);
  cov_finish_freeze: cover property (
    @(posedge clock_i) frz_finish && $rose(frozen_q));

endmodule

// File: dv/adc_seq_model.sv
// Purpose: sampling and conversion sequencer stand-in for the control block
// Assumes: continuous scan of eight channels, eight cycles per conversion
// Notes:   only steps while the block lets its clocks run and is not frozen
module adc_seq_model (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  // control from the block
  input  wire logic       run_en_i,
  input  wire logic       seq_start_i,
  input  wire logic       seq_abort_i,
  input  wire logic       module_reset_i,
  // status to the block
  output logic            seq_active_o,
  output logic            conv_busy_o,
  output logic            sample_start_o,
  output logic            conv_done_o,
  output logic            seq_done_set_o,
  output logic [7:0]      conv_done_set_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [5:0] cnt_q;
  logic       step;

  // start wins over abort so a restart strobe begins a fresh scan
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seq_active_o <= 1'b0;
      cnt_q        <= 6'h00;
    end else if (seq_start_i) begin
      seq_active_o <= 1'b1;
      cnt_q        <= 6'h00;
    end else if (seq_abort_i || module_reset_i) begin
      seq_active_o <= 1'b0;
    end else if (step) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  assign step            = seq_active_o && run_en_i;
  assign sample_start_o  = step && (cnt_q[2:0] == 3'h0);
  assign conv_busy_o     = seq_active_o && (cnt_q[2:0] != 3'h0);
  assign conv_done_o     = step && (cnt_q[2:0] == 3'h7);
  assign conv_done_set_o = conv_done_o ? (8'h01 << cnt_q[5:3]) : 8'h00;
  assign seq_done_set_o  = conv_done_o && (cnt_q[5:3] == 3'h7);
endmodule

// File: dv/adc_power_mode_reset_control_bench.sv
// Purpose: directed bench for the converter power, mode and reset control
// Assumes: mode pins need two edges to sync, so mode changes wait 4 cycles
// Notes:   strobes are driven one cycle wide; same-cycle outputs sampled
module adc_power_mode_reset_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic stop_q = 1'b0, wait_q = 1'b0, dbg_q = 1'b0, spec_q = 1'b0;
  logic pu_q = 1'b0, hw_q = 1'b0;
  logic [1:0] fs_q = 2'h0;
  logic [5:0] wr_q = 6'h00;
  logic [7:0] pin_q = 8'h00;
  logic act, busy, smp, cdone, sdone, pu_o, hw_o, bias, dclk, sclk;
  logic abort, start, mrst, acc, z1, sequence_done_flag, st_seen, ab_seen;
  logic [1:0] fs_o;
  logic [7:0] dset, ccf, port, snap;
  adc_pmr_pkg::adc_state_t st;
  int num_errors = 0;
  int num_checks = 0;

  always #4 clock_i = ~clock_i;

  adc_power_mode_reset_control i_dut (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .chip_stop_i(stop_q),
    .chip_wait_i(wait_q), .background_debug_signal_i(dbg_q),
    .special_mode_i(spec_q), .ctl_two_wr_i(wr_q[0]),
    .power_up_ctl_i(pu_q), .halt_in_wait_ctl_i(hw_q),
    .ctl_three_wr_i(wr_q[1]), .freeze_sel_i(fs_q),
    .ctl_four_wr_i(wr_q[2]), .ctl_five_wr_i(wr_q[3]),
    .soft_reset_wr_i(wr_q[4]), .bus_access_i(1'b0), .port_rd_i(wr_q[5]),
    .seq_active_i(act), .conv_busy_i(busy), .sample_start_i(smp),
    .conv_done_i(cdone), .conv_done_set_i(dset), .seq_done_set_i(sdone),
    .analog_pin_i(pin_q), .power_up_ctl_o(pu_o), .halt_in_wait_ctl_o(hw_o),
    .freeze_sel_o(fs_o), .analog_bias_en_o(bias), .digital_clk_en_o(dclk),
    .submod_clk_en_o(sclk), .seq_abort_o(abort), .seq_start_o(start),
    .module_reset_o(mrst), .reg_access_ok_o(acc),
    .ctl_zero_one_rd_en_o(z1), .conversion_done_flag_o(ccf),
    .sequence_done_flag_o(sequence_done_flag), .analog_pin_port_data_o(port), .state_o(st));

  adc_seq_model i_seq (
    .clock_i(clock_i), .arst_n_i(arst_n_i),
    .run_en_i(dclk && (st != adc_pmr_pkg::ST_FROZEN)),
    .seq_start_i(start), .seq_abort_i(abort), .module_reset_i(mrst),
    .seq_active_o(act), .conv_busy_o(busy), .sample_start_o(smp),
    .conv_done_o(cdone), .seq_done_set_o(sdone), .conv_done_set_o(dset));

  task automatic finish_test();
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // one-cycle strobe; start/abort are sampled inside the strobe cycle
  task automatic strobe(input logic [5:0] s, input logic pu, hw,
                        input logic [1:0] fs);
    @(posedge clock_i);
    wr_q <= s;
    pu_q <= pu;
    hw_q <= hw;
    fs_q <= fs;
    @(negedge clock_i);
    st_seen = start;
    ab_seen = abort;
    @(posedge clock_i);
    wr_q <= 6'h00;
    @(negedge clock_i);
    // a power-bit abort follows the cycle in which the bit lands
    ab_seen = ab_seen | abort;
  endtask

  task automatic mode(input logic [3:0] m, input logic [7:0] p);
    @(posedge clock_i);
    {stop_q, wait_q, dbg_q, spec_q} <= m;
    pin_q <= p;
    cyc(4);
  endtask

  // ----------------------------------------------------------------
  // directed sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock_i);
    arst_n_i <= 1'b1;
    cyc(2);
    chk(st, adc_pmr_pkg::ST_DOWN, "reset state");
    chk({pu_o, bias, dclk, acc}, 4'b0001, "reset power");
    strobe(6'h01, 1'b1, 1'b0, 2'h0);
    chk({pu_o, bias, dclk, sclk, acc}, 5'b11101, "power up");
    chk(st, adc_pmr_pkg::ST_IDLE, "idle state");
    cyc(8);
    strobe(6'h08, 1'b1, 1'b0, 2'h0);
    chk({st_seen, ab_seen}, 2'b11, "ctl five restart");
    // keeps the next restart clear of a conversion end
    cyc(66);
    chk({st, sclk, sequence_done_flag}, {adc_pmr_pkg::ST_RUN, 2'b11}, "running");
    strobe(6'h04, 1'b1, 1'b0, 2'h0);
    chk({st_seen, ab_seen}, 2'b11, "ctl four restart");
    chk({sequence_done_flag, ccf}, 9'h000, "flags cleared");
    cyc(20);
    strobe(6'h03, 1'b1, 1'b0, 2'h3);
    chk({st_seen, ab_seen, fs_o}, 4'h3, "ctl two/three write");
    mode(4'b0010, 8'h00);
    chk({st, bias, acc}, {adc_pmr_pkg::ST_FROZEN, 2'b11}, "frz");
    snap = ccf;
    cyc(20);
    chk(ccf, snap, "frozen hold");
    mode(4'b0000, 8'h00);
    chk(st, adc_pmr_pkg::ST_RUN, "freeze released");
    strobe(6'h02, 1'b1, 1'b0, 2'h0);
    mode(4'b0010, 8'h00);
    chk(st, adc_pmr_pkg::ST_RUN, "freeze ignored");
    mode(4'b0000, 8'h00);
    strobe(6'h02, 1'b1, 1'b0, 2'h2);
    mode(4'b0010, 8'h00);
    cyc(10);
    chk(st, adc_pmr_pkg::ST_FROZEN, "freeze after conversion");
    chk(busy, 1'b0, "frozen between conversions");
    mode(4'b0000, 8'h00);
    mode(4'b0100, 8'h00);
    chk(st, adc_pmr_pkg::ST_RUN, "wait ignored");
    mode(4'b0000, 8'h00);
    strobe(6'h01, 1'b1, 1'b1, 2'h0);
    mode(4'b0100, 8'h00);
    chk({st, acc}, {adc_pmr_pkg::ST_DOWN, 1'b0}, "wait down");
    mode(4'b0000, 8'h00);
    chk({st, pu_o}, {adc_pmr_pkg::ST_RUN, 1'b1}, "wait resume");
    mode(4'b0000, 8'ha5);
    strobe(6'h20, 1'b1, 1'b1, 2'h0);
    chk({ab_seen, port}, 9'h0a5, "port read");
    mode(4'b0001, 8'h5a);
    chk(z1, 1'b1, "special mode read");
    mode(4'b0000, 8'h5a);
    chk(z1, 1'b0, "normal mode read");
    strobe(6'h10, 1'b1, 1'b1, 2'h3);
    chk({st_seen, pu_o}, 2'b01, "soft reset power bit");
    chk(st, adc_pmr_pkg::ST_IDLE, "soft reset idle");
    chk({hw_o, fs_o, sequence_done_flag, ccf}, 12'h000, "soft reset clears");
    strobe(6'h08, 1'b1, 1'b0, 2'h0);
    cyc(5);
    mode(4'b1000, 8'h00);
    chk({st, bias, dclk, act}, {adc_pmr_pkg::ST_DOWN, 3'b000}, "stop");
    mode(4'b0000, 8'h00);
    chk(st, adc_pmr_pkg::ST_IDLE, "stop released");
    strobe(6'h08, 1'b1, 1'b0, 2'h0);
    cyc(5);
    strobe(6'h01, 1'b0, 1'b0, 2'h0);
    chk({ab_seen, bias, dclk}, 3'b100, "bit clear abort");
    chk(st, adc_pmr_pkg::ST_DOWN, "bit clear down");
    cyc(1);
    chk(act, 1'b0, "sequence aborted");
    finish_test();
  end

  initial begin
    repeat (5000) @(posedge clock_i);
    num_errors++;
    finish_test();
  end
endmodule
